// ==== ssq_top.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Sleep request is async active high; while high, chip sleeps and is deselected.
// - Sleep follows sleep request high, lagging it three cycles each way; leaves only after it falls.
// - Asleep, all inputs but sleep request are ignored; data outputs float.
// - Input sampling stops no later than two cycles after sleep request rises.
// - Input sampling resumes two cycles after sleep request falls.
// - Sleep current is reached within three cycles of sleep request rising.
// - Advance low with chip selected starts a write if write enable low, else a read.
// - External address captured only when advance low and chip selected.
// - Clock enable high ignores the edge; state, address, operation held.
// - Continued-deselect only follows a deselect, continued-deselect or idle cycle.
module ssq_top
  import ssq_pkg::*;
#(
  parameter int unsigned AW = ssq_pkg::ADDR_W,
  parameter int unsigned NL = ssq_pkg::LANES
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Sleep
  input wire logic SLEEP_REQUEST,
  output logic SLEEP_ACTIVE,
  output logic SLEEP_CURRENT,
  // Cycle qualification pins
  input wire logic CHIP_SELECT_FIRST_N,
  input wire logic CHIP_SELECT_SECOND,
  input wire logic CHIP_SELECT_THIRD_N,
  input wire logic ADVANCE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [NL-1:0] BYTE_LANE_WRITE_N,
  input wire logic CLOCK_ENABLE_N,
  input wire logic [AW-1:0] ADDRESS,
  // Qualified cycle
  output logic [AW-1:0] CYCLE_ADDRESS,
  output logic CYCLE_READ,
  output logic CYCLE_WRITE,
  output logic [NL-1:0] CYCLE_LANE_WRITE,
  output logic CYCLE_CONT_DESEL,
  output logic INPUTS_SAMPLED,
  output logic DATA_OUT_ENABLE
);
  import ssq_pkg::*;

  logic sleep_sync;
  logic sample_en_ff;
  logic nxt_sample_en;
  logic sleep_active_ff;
  logic sleep_current_ff;
  ssq_cycle_t cycle_ff;
  ssq_cycle_t nxt_cycle;
  logic [AW-1:0] addr_ff;
  logic [NL-1:0] lanes_ff;
  logic selected;
  logic take_edge;
  logic [NL-1:0] nxt_lanes;
  logic read_ff;
  logic write_ff;
  logic cont_desel_ff;
  logic [NL-1:0] lane_write_ff;
  logic doe_ff;

  function automatic logic chip_selected(input logic s1n, input logic s2, input logic s3n);
    return (!s1n) && s2 && (!s3n);
  endfunction

  // Async pin made synchronous through two flops; output changes on the second rising edge after the pin, each way
  ssq_sync u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .din(SLEEP_REQUEST),
    .dout(sleep_sync)
  );

  // Sampling gate follows the synchronised level; entry and exit both two edges
  assign nxt_sample_en = !sleep_sync;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sample_en_ff <= 1'b1;
      sleep_active_ff <= RST_ZERO;
      sleep_current_ff <= RST_ZERO;
    end else begin
      sample_en_ff <= nxt_sample_en;
      sleep_active_ff <= sleep_sync;
      sleep_current_ff <= sleep_sync;
    end
  end

  assign selected = chip_selected(CHIP_SELECT_FIRST_N, CHIP_SELECT_SECOND, CHIP_SELECT_THIRD_N);
  // Edge is used only when awake and clock enable low
  assign take_edge = nxt_sample_en && !CLOCK_ENABLE_N;

  always_comb begin
    nxt_cycle = cycle_ff;
    if (!nxt_sample_en) begin
      nxt_cycle = SSQ_IDLE;
    end else if (take_edge) begin
      if (!ADVANCE_N) begin
        if (!selected) begin
          nxt_cycle = SSQ_DESEL;
        end else if (!WRITE_ENABLE_N) begin
          nxt_cycle = SSQ_WRITE;
        end else begin
          nxt_cycle = SSQ_READ;
        end
      end else begin
        unique case (cycle_ff)
          SSQ_DESEL, SSQ_CONT_DESEL, SSQ_IDLE: nxt_cycle = SSQ_CONT_DESEL;
          SSQ_READ: nxt_cycle = SSQ_READ;
          SSQ_WRITE: nxt_cycle = SSQ_WRITE;
          default: nxt_cycle = SSQ_IDLE;
        endcase
      end
    end
  end

  // Idle after wake counts as deselected, so continue-deselect may follow it
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cycle_ff <= SSQ_IDLE;
    end else begin
      cycle_ff <= nxt_cycle;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      addr_ff <= '0;
    end else if (take_edge && !ADVANCE_N && selected) begin
      addr_ff <= ADDRESS;
    end
  end

  // Byte writes are sampled on each used edge, including burst continues
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lanes_ff <= '0;
    end else begin
      lanes_ff <= nxt_lanes;
    end
  end

  // Lane enables as they will stand after this edge
  always_comb begin
    nxt_lanes = lanes_ff;
    if (!nxt_sample_en) begin
      nxt_lanes = '0;
    end else if (take_edge) begin
      nxt_lanes = ~BYTE_LANE_WRITE_N;
    end
  end

  // Outputs registered from the next state, so they track cycle_ff edge for edge
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      read_ff <= RST_ZERO;
      write_ff <= RST_ZERO;
      cont_desel_ff <= RST_ZERO;
      lane_write_ff <= '0;
      doe_ff <= RST_ZERO;
    end else begin
      read_ff <= (nxt_cycle == SSQ_READ);
      write_ff <= (nxt_cycle == SSQ_WRITE);
      cont_desel_ff <= (nxt_cycle == SSQ_CONT_DESEL);
      lane_write_ff <= (nxt_cycle == SSQ_WRITE) ? nxt_lanes : '0;
      // Outputs float while asleep
      doe_ff <= (nxt_cycle == SSQ_READ) && !sleep_sync;
    end
  end

  assign SLEEP_ACTIVE = sleep_active_ff;
  assign SLEEP_CURRENT = sleep_current_ff;
  assign CYCLE_ADDRESS = addr_ff;
  assign CYCLE_READ = read_ff;
  assign CYCLE_WRITE = write_ff;
  assign CYCLE_LANE_WRITE = lane_write_ff;
  assign CYCLE_CONT_DESEL = cont_desel_ff;
  assign INPUTS_SAMPLED = sample_en_ff;
  assign DATA_OUT_ENABLE = doe_ff;

  sequence s_sleep_rise;
    $rose(SLEEP_REQUEST) ##1 SLEEP_REQUEST;
  endsequence

  sequence s_sleep_fall;
    $fell(SLEEP_REQUEST) ##1 !SLEEP_REQUEST;
  endsequence

  chk_sleep_entry: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    s_sleep_rise |=> !nxt_sample_en) else $error("sampling not stopped two cycles after sleep rise");

  chk_sleep_exit: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    s_sleep_fall |=> nxt_sample_en) else $error("sampling not resumed two cycles after sleep fall");

  chk_sleep_current: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    s_sleep_rise |=> ##1 SLEEP_CURRENT) else $error("sleep current late");

  chk_sleep_holds: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    SLEEP_REQUEST [*4] |-> SLEEP_ACTIVE) else $error("left sleep while request high");

  chk_sleep_deselect: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    SLEEP_ACTIVE |-> !CYCLE_READ && !CYCLE_WRITE) else $error("active cycle during sleep");

  chk_sleep_hiz: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    SLEEP_ACTIVE |-> !DATA_OUT_ENABLE) else $error("outputs driven during sleep");

  chk_cke_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (CLOCK_ENABLE_N && nxt_sample_en) |=> $stable(CYCLE_ADDRESS) && $stable(cycle_ff))
    else $error("state changed on ignored edge");

  chk_write_start: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take_edge && !ADVANCE_N && selected && !WRITE_ENABLE_N) |=> CYCLE_WRITE) else $error("write not begun");

  chk_addr_capture: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take_edge && !ADVANCE_N && selected) |=> CYCLE_ADDRESS == $past(ADDRESS)) else $error("address not captured");

  chk_cont_desel: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(CYCLE_CONT_DESEL) |-> $past(cycle_ff) inside {SSQ_DESEL, SSQ_IDLE}) else $error("bad continue deselect");

  chk_select_decode: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take_edge && !ADVANCE_N && CHIP_SELECT_FIRST_N) |=> !CYCLE_READ && !CYCLE_WRITE) else $error("selected wrongly");

  chk_lane_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (CYCLE_LANE_WRITE != '0) |-> CYCLE_WRITE) else $error("lane write outside write cycle");
endmodule // ssq_top

// ==== ssq_pkg.sv ====
package ssq_pkg;
  // Sleep entry and exit delays, in clock cycles
  localparam int unsigned SLEEP_ENTRY_CYC = 2;
  localparam int unsigned SLEEP_EXIT_CYC = 2;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Widths
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_W = 9;
  // Reset values
  localparam logic RST_ZERO = 1'b0;
  // Cycle kinds
  typedef enum logic [4:0] {
    SSQ_IDLE = 5'h01,
    SSQ_READ = 5'h02,
    SSQ_WRITE = 5'h04,
    SSQ_DESEL = 5'h08,
    SSQ_CONT_DESEL = 5'h10
  } ssq_cycle_t;
endpackage

// ==== ssq_sync.sv ====
`timescale 1ns/100ps
module ssq_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;

  // Only sync_ff reads meta_ff
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // ssq_sync

// ==== ssq_host.sv ====
`timescale 1ns/100ps
module ssq_host
  import ssq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Select pins
  output logic chip_select_first_n,
  output logic chip_select_second,
  output logic chip_select_third_n,
  // Cycle control pins
  output logic advance_n,
  output logic we_n,
  output logic cke_n,
  output logic [3:0] lanes_n,
  output logic [ssq_pkg::ADDR_W-1:0] addr
);
  import ssq_pkg::*;
  // Start as a plain deselect so a continue may follow
  initial {chip_select_first_n, chip_select_second, chip_select_third_n, advance_n, we_n, cke_n,
    lanes_n, addr} = {6'h30, 4'hF, 18'h0};
  // Drive only off the sampling edge
  task automatic issue(input logic [2:0] sel, input logic step_n, we, cke, input logic [3:0] ln,
                       input logic [17:0] a);
    @(negedge clk);
    {chip_select_first_n, chip_select_second, chip_select_third_n} = sel;
    advance_n = step_n;
    we_n = we;
    cke_n = cke;
    lanes_n = ln;
    addr = a;
  endtask
endmodule // ssq_host

// ==== ssq_top_test.sv ====
`timescale 1ns/100ps
module ssq_top_test;
  import ssq_pkg::*;
  localparam logic [2:0] SEL = 3'b010;
  logic clk, nrst, slp, act, cur, rd, wr, cd, smp, doe;
  logic sel1_n, sel2, sel3_n, advance_n, we_n, cke_n;
  logic [3:0] ln_n, lw;
  logic [17:0] a, caddr;
  int miscompares = 0;
  int checks = 0;
  ssq_host h (.clk(clk), .chip_select_first_n(sel1_n), .chip_select_second(sel2),
    .chip_select_third_n(sel3_n), .advance_n(advance_n), .we_n(we_n), .cke_n(cke_n), .lanes_n(ln_n),
    .addr(a));
  ssq_top DUT (.CLK_SYS(clk), .NRST(nrst), .SLEEP_REQUEST(slp), .SLEEP_ACTIVE(act),
    .SLEEP_CURRENT(cur), .CHIP_SELECT_FIRST_N(sel1_n), .CHIP_SELECT_SECOND(sel2),
    .CHIP_SELECT_THIRD_N(sel3_n), .ADVANCE_N(advance_n), .WRITE_ENABLE_N(we_n),
    .BYTE_LANE_WRITE_N(ln_n), .CLOCK_ENABLE_N(cke_n), .ADDRESS(a), .CYCLE_ADDRESS(caddr),
    .CYCLE_READ(rd), .CYCLE_WRITE(wr), .CYCLE_LANE_WRITE(lw), .CYCLE_CONT_DESEL(cd),
    .INPUTS_SAMPLED(smp), .DATA_OUT_ENABLE(doe));
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs stand two edges; results read at the falling edge
  task automatic op(input logic [2:0] s, input logic v, w, k, input logic [3:0] l,
                    input logic [17:0] d);
    h.issue(s, v, w, k, l, d);
    @(negedge clk);
  endtask
  task automatic t_rw;
    op(SEL, 0, 1, 0, 4'hF, 18'h00155);
    chk(rd, 1);
    chk(caddr, 18'h00155);
    chk(doe, 1);
    op(SEL, 0, 0, 0, 4'hA, 18'h002AA);
    chk(wr, 1);
    chk(lw, 4'h5);
    op(3'b110, 0, 1, 0, 4'hF, 18'h00003);
    chk(caddr, 18'h002AA);
    chk(rd, 0);
    op(3'b000, 0, 1, 0, 4'hF, 18'h00005);
    chk(caddr, 18'h002AA);
    chk(rd, 0);
    op(3'b011, 0, 1, 0, 4'hF, 18'h00006);
    chk(caddr, 18'h002AA);
    chk(rd, 0);
    op(SEL, 1, 1, 0, 4'hF, 18'h00004);
    chk(cd, 1);
    op(SEL, 0, 0, 0, 4'h0, 18'h00009);
    chk(wr, 1);
    chk(lw, 4'hF);
    op(SEL, 1, 0, 0, 4'h0, 18'h0000C);
    chk(cd, 0);
    chk(wr, 1);
    chk(caddr, 18'h00009);
    $display("t_rw done");
  endtask
  task automatic t_cke;
    op(SEL, 0, 1, 0, 4'hF, 18'h00011);
    op(SEL, 0, 0, 1, 4'h0, 18'h00022);
    chk(caddr, 18'h00011);
    chk(wr, 0);
    chk(rd, 1);
    $display("t_cke done");
  endtask
  task automatic t_sleep;
    op(3'b110, 0, 1, 0, 4'hF, 18'h0);
    slp = 1;
    @(negedge clk);
    chk(act, 0);
    repeat (2) @(negedge clk);
    chk(act, 1);
    chk(cur, 1);
    chk(smp, 0);
    op(SEL, 0, 1, 0, 4'hF, 18'h0003F);
    chk(caddr, 18'h00011);
    chk(doe, 0);
    chk(rd, 0);
    op(3'b110, 0, 1, 0, 4'hF, 18'h0);
    slp = 0;
    @(negedge clk);
    chk(act, 1);
    repeat (2) @(negedge clk);
    chk(smp, 1);
    op(SEL, 0, 1, 0, 4'hF, 18'h00007);
    chk(rd, 1);
    chk(caddr, 18'h00007);
    $display("t_sleep done");
  endtask
  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs well under 100 cycles
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
  initial begin
    clk = 0;
    nrst = 0;
    slp = 0;
    repeat (10) @(negedge clk);
    nrst = 1;
    t_rw;
    t_cke;
    t_sleep;
    wrap_up;
  end
endmodule // ssq_top_test
